/* File: src/ubd_defs.vh */
`ifndef UBD_DEFS_VH
`define UBD_DEFS_VH

// ==========================================================
// Register addresses
`define UBD_A_DATA 4'h0
`define UBD_A_IER 4'h1
`define UBD_A_ISR 4'h2
`define UBD_A_LCR 4'h3
`define UBD_A_MCR 4'h4
`define UBD_A_LSR 4'h5
`define UBD_A_MSR 4'h6
`define UBD_A_SPR 4'h7
`define UBD_A_TXLV 4'h8
`define UBD_A_RXLV 4'h9
`define UBD_A_GDIR 4'hA
`define UBD_A_GPIN 4'hB
`define UBD_A_GIEN 4'hC
`define UBD_A_RSVD 4'hD
`define UBD_A_GCTL 4'hE
`define UBD_A_XFC 4'hF

// ==========================================================
// Bank selection values and bit positions
`define UBD_LCR_ENH_KEY 8'hBF
`define UBD_LCR_DIV_BIT 7
`define UBD_EFR_ENH_BIT 4
`define UBD_MCR_TCR_BIT 2

// ==========================================================
// Masks of the bits that are gated by the enhanced enable, then the level mask and the write masks
`define UBD_IER_ENH_MASK 8'hF0
`define UBD_ISR_ENH_MASK 8'h30
`define UBD_FCR_ENH_MASK 8'h30
`define UBD_MCR_ENH_MASK 8'hE0
`define UBD_LVL_MASK 8'h7F
`define UBD_GCTL_MASK 8'h0B
`define UBD_XFC_MASK 8'hB7

// ==========================================================
// Reset values and constants
`define UBD_RST_BYTE 8'h00
`define UBD_ZERO_BYTE 8'h00
`define UBD_ALL_ONES 8'hFF

`endif

/* File: src/ubd_register_bank.v */
`timescale 1ns/1ps
`include "ubd_defs.vh"

module ubd_register_bank (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [3:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	input wire [7:0] rx_char_in,
	input wire [7:0] isr_value_in,
	input wire [7:0] lsr_value_in,
	input wire [7:0] msr_value_in,
	input wire [7:0] tx_space_in,
	input wire [7:0] rx_fill_in,
	input wire [7:0] gpio_pins_in,
	output reg rx_pop_out,
	output reg tx_push_out,
	output reg [7:0] tx_char_out,
	output reg fcr_wr_out,
	output reg [7:0] fcr_value_out,
	output reg isr_rd_out,
	output reg lsr_rd_out,
	output reg msr_rd_out,
	output wire [7:0] baud_div_low_out,
	output wire [7:0] baud_div_high_out,
	output wire [7:0] baud_div_frac_out,
	output wire [7:0] line_control_out,
	output wire [7:0] interrupt_enable_out,
	output wire [7:0] modem_control_out,
	output wire [7:0] enhanced_function_out,
	output wire [7:0] transmission_control_out,
	output wire [7:0] trigger_level_out,
	output wire [7:0] flow_start_one_out,
	output wire [7:0] flow_start_two_out,
	output wire [7:0] flow_stop_one_out,
	output wire [7:0] flow_stop_two_out,
	output wire [7:0] gpio_direction_out,
	output wire [7:0] gpio_out_value_out,
	output wire [7:0] gpio_irq_enable_out,
	output wire [7:0] gpio_io_control_out,
	output wire [7:0] extra_features_out
);

	// ==========================================================
	// Reset release
	reg rst_meta_q;
	reg rst_sync_q;
	wire rst_n;

	// Two-stage release so the deassertion edge is clean
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// ==========================================================
	// Stored registers
	// Divisor bank: baud divisor bytes and the fraction
	reg [7:0] dll_q;
	reg [7:0] dlm_q;
	reg [7:0] dld_q;
	// Normal bank: interrupt enable, line and modem control, scratch
	reg [7:0] ier_q;
	reg [7:0] lcr_q;
	reg [7:0] mcr_q;
	reg [7:0] spr_q;
	// Swapped in at 6 and 7 while modem control bit 2 is set, outside the key bank
	reg [7:0] tcr_q;
	reg [7:0] tlr_q;
	// Enhanced bank: function register and flow characters
	reg [7:0] efr_q;
	reg [7:0] xon1_q;
	reg [7:0] xon2_q;
	reg [7:0] xoff1_q;
	reg [7:0] xoff2_q;
	// Bank-independent registers above address 7
	reg [7:0] gdir_q;
	reg [7:0] gout_q;
	reg [7:0] gien_q;
	reg [7:0] gctl_q;
	reg [7:0] xfc_q;

	// ==========================================================
	// Bank selection
	wire enh_key = (lcr_q == `UBD_LCR_ENH_KEY);
	wire div_bank = lcr_q[`UBD_LCR_DIV_BIT] & ~enh_key;
	wire norm_bank = ~lcr_q[`UBD_LCR_DIV_BIT];
	wire enh_en = efr_q[`UBD_EFR_ENH_BIT];
	wire tcr_sel = mcr_q[`UBD_MCR_TCR_BIT];
	// Masks clearing the enhanced-only bits while disabled
	// Gating at both write and read keeps stale high bits from
	// reappearing when the enhanced enable is later turned on
	wire [7:0] ier_gate = enh_en ? `UBD_ALL_ONES : ~`UBD_IER_ENH_MASK;
	wire [7:0] isr_gate = enh_en ? `UBD_ALL_ONES : ~`UBD_ISR_ENH_MASK;
	wire [7:0] fcr_gate = enh_en ? `UBD_ALL_ONES : ~`UBD_FCR_ENH_MASK;
	wire [7:0] mcr_gate = enh_en ? `UBD_ALL_ONES : ~`UBD_MCR_ENH_MASK;

	// ==========================================================
	// Write decode
	// One enable per storage target; at most one is high per write
	reg wr_dll;
	reg wr_dlm;
	reg wr_dld;
	reg wr_ier;
	reg wr_lcr;
	reg wr_mcr;
	reg wr_spr;
	reg wr_tcr;
	reg wr_tlr;
	reg wr_efr;
	reg wr_xon1;
	reg wr_xon2;
	reg wr_xoff1;
	reg wr_xoff2;
	reg wr_gdir;
	reg wr_gout;
	reg wr_gien;
	reg wr_gctl;
	reg wr_xfc;
	// Transmit and FIFO control writes leave as strobes, not storage
	reg wr_thr;
	reg wr_fcr;

	// Read-only targets and the reserved slot decode to nothing
	// Bank terms are taken from the stored line control, so a bank
	// change is only seen by the access after the line control write
	always @* begin
		wr_dll = 1'b0;
		wr_dlm = 1'b0;
		wr_dld = 1'b0;
		wr_ier = 1'b0;
		wr_lcr = 1'b0;
		wr_mcr = 1'b0;
		wr_spr = 1'b0;
		wr_tcr = 1'b0;
		wr_tlr = 1'b0;
		wr_efr = 1'b0;
		wr_xon1 = 1'b0;
		wr_xon2 = 1'b0;
		wr_xoff1 = 1'b0;
		wr_xoff2 = 1'b0;
		wr_gdir = 1'b0;
		wr_gout = 1'b0;
		wr_gien = 1'b0;
		wr_gctl = 1'b0;
		wr_xfc = 1'b0;
		wr_thr = 1'b0;
		wr_fcr = 1'b0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`UBD_A_DATA: begin
					wr_thr = norm_bank;
					wr_dll = div_bank;
				end
				`UBD_A_IER: begin
					wr_ier = norm_bank;
					wr_dlm = div_bank;
				end
				// Fraction is refused unless the enhanced enable is set
				`UBD_A_ISR: begin
					wr_fcr = norm_bank;
					wr_dld = div_bank & enh_en;
					wr_efr = enh_key;
				end
				`UBD_A_LCR: wr_lcr = 1'b1;
				`UBD_A_MCR: begin
					wr_mcr = ~enh_key;
					wr_xon1 = enh_key;
				end
				// Line status is read-only; only the key bank writes here
				`UBD_A_LSR: wr_xon2 = enh_key;
				// Modem status is read-only; outside the key bank a write with no swap is lost
				`UBD_A_MSR: begin
					wr_tcr = ~enh_key & tcr_sel;
					wr_xoff1 = enh_key;
				end
				`UBD_A_SPR: begin
					wr_spr = ~enh_key & ~tcr_sel;
					wr_tlr = ~enh_key & tcr_sel;
					wr_xoff2 = enh_key;
				end
				// Addresses 8 and 9 are levels and fall to the default
				`UBD_A_GDIR: wr_gdir = 1'b1;
				`UBD_A_GPIN: wr_gout = 1'b1;
				`UBD_A_GIEN: wr_gien = 1'b1;
				`UBD_A_GCTL: wr_gctl = 1'b1;
				`UBD_A_XFC: wr_xfc = 1'b1;
				default: wr_xfc = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Register storage; gated bits are dropped on write
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			dll_q <= `UBD_RST_BYTE;
			dlm_q <= `UBD_RST_BYTE;
			dld_q <= `UBD_RST_BYTE;
			ier_q <= `UBD_RST_BYTE;
			lcr_q <= `UBD_RST_BYTE;
			mcr_q <= `UBD_RST_BYTE;
			spr_q <= `UBD_RST_BYTE;
			tcr_q <= `UBD_RST_BYTE;
			tlr_q <= `UBD_RST_BYTE;
			efr_q <= `UBD_RST_BYTE;
			xon1_q <= `UBD_RST_BYTE;
			xon2_q <= `UBD_RST_BYTE;
			xoff1_q <= `UBD_RST_BYTE;
			xoff2_q <= `UBD_RST_BYTE;
			gdir_q <= `UBD_RST_BYTE;
			gout_q <= `UBD_RST_BYTE;
			gien_q <= `UBD_RST_BYTE;
			gctl_q <= `UBD_RST_BYTE;
			xfc_q <= `UBD_RST_BYTE;
		end else begin
			if (wr_dll) dll_q <= reg_wdata_in;
			if (wr_dlm) dlm_q <= reg_wdata_in;
			if (wr_dld) dld_q <= reg_wdata_in;
			if (wr_ier) ier_q <= reg_wdata_in & ier_gate;
			if (wr_lcr) lcr_q <= reg_wdata_in;
			if (wr_mcr) mcr_q <= reg_wdata_in & mcr_gate;
			if (wr_spr) spr_q <= reg_wdata_in;
			if (wr_tcr) tcr_q <= reg_wdata_in;
			if (wr_tlr) tlr_q <= reg_wdata_in;
			if (wr_efr) efr_q <= reg_wdata_in;
			if (wr_xon1) xon1_q <= reg_wdata_in;
			if (wr_xon2) xon2_q <= reg_wdata_in;
			if (wr_xoff1) xoff1_q <= reg_wdata_in;
			if (wr_xoff2) xoff2_q <= reg_wdata_in;
			if (wr_gdir) gdir_q <= reg_wdata_in;
			if (wr_gout) gout_q <= reg_wdata_in;
			if (wr_gien) gien_q <= reg_wdata_in;
			if (wr_gctl) gctl_q <= reg_wdata_in & `UBD_GCTL_MASK;
			if (wr_xfc) xfc_q <= reg_wdata_in & `UBD_XFC_MASK;
		end
	end

	// ==========================================================
	// Read multiplexer
	reg [7:0] rd_mux;

	// Unmapped combinations read as zero
	always @* begin
		rd_mux = `UBD_ZERO_BYTE;
		case (reg_addr_in)
			`UBD_A_DATA: begin
				if (norm_bank) rd_mux = rx_char_in;
				else if (div_bank) rd_mux = dll_q;
			end
			`UBD_A_IER: begin
				if (norm_bank) rd_mux = ier_q & ier_gate;
				else if (div_bank) rd_mux = dlm_q;
			end
			`UBD_A_ISR: begin
				if (enh_key) rd_mux = efr_q;
				else if (norm_bank) rd_mux = isr_value_in & isr_gate;
				else if (enh_en) rd_mux = dld_q;
			end
			`UBD_A_LCR: rd_mux = lcr_q;
			// Modem control reads back gated, as the engine sees it
			`UBD_A_MCR: rd_mux = enh_key ? xon1_q : mcr_q & mcr_gate;
			`UBD_A_LSR: rd_mux = enh_key ? xon2_q : lsr_value_in;
			`UBD_A_MSR: begin
				if (enh_key) rd_mux = xoff1_q;
				else if (tcr_sel) rd_mux = tcr_q;
				else rd_mux = msr_value_in;
			end
			`UBD_A_SPR: begin
				if (enh_key) rd_mux = xoff2_q;
				else if (tcr_sel) rd_mux = tlr_q;
				else rd_mux = spr_q;
			end
			// Levels never exceed the FIFO depth; bit 7 is forced low
			`UBD_A_TXLV: rd_mux = tx_space_in & `UBD_LVL_MASK;
			`UBD_A_RXLV: rd_mux = rx_fill_in & `UBD_LVL_MASK;
			`UBD_A_GDIR: rd_mux = gdir_q;
			`UBD_A_GPIN: rd_mux = gpio_pins_in;
			`UBD_A_GIEN: rd_mux = gien_q;
			`UBD_A_GCTL: rd_mux = gctl_q;
			`UBD_A_XFC: rd_mux = xfc_q;
			default: rd_mux = `UBD_ZERO_BYTE;
		endcase
	end

	// ==========================================================
	// Read data and side-effect strobes, all one cycle after request
	// Strobes let the serial engine pop or clear on the read itself
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_out <= `UBD_ZERO_BYTE;
			rx_pop_out <= 1'b0;
			isr_rd_out <= 1'b0;
			lsr_rd_out <= 1'b0;
			msr_rd_out <= 1'b0;
			tx_push_out <= 1'b0;
			tx_char_out <= `UBD_ZERO_BYTE;
			fcr_wr_out <= 1'b0;
			fcr_value_out <= `UBD_ZERO_BYTE;
		end else begin
			if (reg_rd_in)
				reg_rdata_out <= rd_mux;
			rx_pop_out <= reg_rd_in & norm_bank &
				(reg_addr_in == `UBD_A_DATA);
			isr_rd_out <= reg_rd_in & norm_bank & ~enh_key &
				(reg_addr_in == `UBD_A_ISR);
			lsr_rd_out <= reg_rd_in & ~enh_key &
				(reg_addr_in == `UBD_A_LSR);
			msr_rd_out <= reg_rd_in & ~enh_key & ~tcr_sel &
				(reg_addr_in == `UBD_A_MSR);
			tx_push_out <= wr_thr;
			fcr_wr_out <= wr_fcr;
			if (wr_thr)
				tx_char_out <= reg_wdata_in;
			if (wr_fcr)
				fcr_value_out <= reg_wdata_in & fcr_gate;
		end
	end

	// ==========================================================
	// Configuration seen by the serial engine, gated as read back except the fraction, which the engine sees ungated
	assign baud_div_low_out = dll_q;
	assign baud_div_high_out = dlm_q;
	assign baud_div_frac_out = dld_q;
	assign line_control_out = lcr_q;
	assign interrupt_enable_out = ier_q & ier_gate;
	assign modem_control_out = mcr_q & mcr_gate;
	assign enhanced_function_out = efr_q;
	assign transmission_control_out = tcr_q;
	assign trigger_level_out = tlr_q;
	assign flow_start_one_out = xon1_q;
	assign flow_start_two_out = xon2_q;
	assign flow_stop_one_out = xoff1_q;
	assign flow_stop_two_out = xoff2_q;
	assign gpio_direction_out = gdir_q;
	assign gpio_out_value_out = gout_q;
	assign gpio_irq_enable_out = gien_q;
	assign gpio_io_control_out = gctl_q;
	assign extra_features_out = xfc_q;

endmodule

/* File: sim/ubd_bank_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks of the bank decode; bank follows line_control
module ubd_bank_checker (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [3:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	input wire [7:0] reg_rdata_out,
	input wire [7:0] tx_space_in,
	input wire rx_pop_out,
	input wire tx_push_out,
	input wire [7:0] tx_char_out,
	input wire fcr_wr_out,
	input wire [7:0] fcr_value_out,
	input wire [7:0] baud_div_low_out,
	input wire [7:0] line_control_out,
	input wire [7:0] interrupt_enable_out,
	input wire [7:0] modem_control_out,
	input wire [7:0] enhanced_function_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Bank qualifiers, decoded from the registered line control
	wire nrm = !line_control_out[7];
	wire dvb = line_control_out[7] && line_control_out != 8'hBF;
	wire w0 = reg_wr_in && reg_addr_in == 4'h0;
	property p_pop;
		reg_rd_in && reg_addr_in == 4'h0 && nrm |=> rx_pop_out;
	endproperty
	a_pop: assert property (p_pop) else $error("no pop");
	property p_push;
		w0 && nrm |=> tx_push_out && tx_char_out == $past(reg_wdata_in);
	endproperty
	a_push: assert property (p_push) else $error("bad push");
	property p_div;
		w0 && dvb |=> baud_div_low_out == $past(reg_wdata_in) && !tx_push_out;
	endproperty
	a_div: assert property (p_div) else $error("bad divisor");
	property p_fcr;
		reg_wr_in && reg_addr_in == 4'h2 && nrm |=> fcr_wr_out &&
		fcr_value_out == ($past(reg_wdata_in) &
		($past(enhanced_function_out[4]) ? 8'hFF : 8'hCF));
	endproperty
	a_fcr: assert property (p_fcr) else $error("bad fifo ctl");
	property p_lcr;
		reg_wr_in && reg_addr_in == 4'h3 |=> line_control_out == $past(reg_wdata_in);
	endproperty
	a_lcr: assert property (p_lcr) else $error("bad line ctl");
	// Gated interrupt enable and modem control bits must never leak while the enhanced enable is off
	property p_gate;
		!enhanced_function_out[4] |->
		interrupt_enable_out[7:4] == 4'h0 && modem_control_out[7:5] == 3'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("gate leak");
	property p_rsvd;
		reg_rd_in && reg_addr_in == 4'hD |=> reg_rdata_out == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved");
	property p_lvl;
		reg_rd_in && reg_addr_in == 4'h8 |=>
		reg_rdata_out == {1'b0, $past(tx_space_in[6:0])};
	endproperty
	a_lvl: assert property (p_lvl) else $error("bad level");
	c_div: cover property (w0 && dvb);
	c_push: cover property (w0 && nrm);
	c_key: cover property (reg_wr_in && line_control_out == 8'hBF);
endmodule

bind ubd_register_bank ubd_bank_checker chk_u (.clk_sys_in, .rst_n_in,
	.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
	.tx_space_in, .rx_pop_out, .tx_push_out, .tx_char_out, .fcr_wr_out,
	.fcr_value_out, .baud_div_low_out, .line_control_out,
	.interrupt_enable_out, .modem_control_out, .enhanced_function_out);

/* File: sim/ubd_engine_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Serial engine stand-in: receive stream, status and levels
module ubd_engine_model (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire rx_pop_in,
	output reg [7:0] rx_char_out,
	output wire [7:0] status_out,
	output wire [7:0] level_out
);
	// Next character only after the current one was taken
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_char_out <= 8'hA5;
		end else if (rx_pop_in) begin
			rx_char_out <= rx_char_out + 8'h35;
		end
	end
	// Bit 7 of the level is set so that masking shows
	assign status_out = rx_char_out ^ 8'h5A;
	assign level_out = 8'h80 | rx_char_out;
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the register bank decode
module tb;
	reg clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in;
	reg [3:0] reg_addr_in;
	reg [7:0] reg_wdata_in, gpio_pins_in, lf, ch, d;
	wire [7:0] reg_rdata_out, rx_c, st, lv, gout, divh;
	wire rx_pop_out;
	integer miscompares = 0, checks = 0, i;
	ubd_register_bank dut_u (.clk_sys_in, .rst_n_in, .reg_addr_in,
		.reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.rx_char_in(rx_c), .isr_value_in(st), .lsr_value_in(st),
		.msr_value_in(st), .tx_space_in(lv), .rx_fill_in(lv), .gpio_pins_in,
		.rx_pop_out, .tx_push_out(), .tx_char_out(), .fcr_wr_out(),
		.fcr_value_out(), .isr_rd_out(), .lsr_rd_out(), .msr_rd_out(),
		.baud_div_low_out(), .baud_div_high_out(divh),
		.baud_div_frac_out(),
		.line_control_out(), .interrupt_enable_out(), .modem_control_out(),
		.enhanced_function_out(), .transmission_control_out(),
		.trigger_level_out(), .flow_start_one_out(), .flow_start_two_out(),
		.flow_stop_one_out(), .flow_stop_two_out(), .gpio_direction_out(),
		.gpio_out_value_out(gout), .gpio_irq_enable_out(),
		.gpio_io_control_out(), .extra_features_out());
	ubd_engine_model eng_u (.clk_sys_in, .rst_n_in, .rx_pop_in(rx_pop_out),
		.rx_char_out(rx_c), .status_out(st), .level_out(lv));
	function [7:0] nx(input [7:0] x);
		nx = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function [7:0] stat(input [7:0] c);
		stat = c ^ 8'h5A;
	endfunction
	task wr(input [3:0] a, input [7:0] v);
		begin
			@(posedge clk_sys_in);
			reg_wr_in <= 1'b1;
			reg_addr_in <= a;
			reg_wdata_in <= v;
			@(posedge clk_sys_in);
			reg_wr_in <= 1'b0;
		end
	endtask
	// One comparison; called only where the value has settled
	task chk(input [7:0] g, input [7:0] e);
		begin
			checks = checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	// Read data lands on the same edge that takes the strobe
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge clk_sys_in);
			reg_rd_in <= 1'b1;
			reg_addr_in <= a;
			@(posedge clk_sys_in);
			reg_rd_in <= 1'b0;
			#1;
			chk(reg_rdata_out, e);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Whole run is under 400 cycles; this is far beyond it
	initial begin
		#200000;
		miscompares = miscompares + 1;
		complete_run;
	end
	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in} = 7'h00;
		reg_wdata_in = 8'h00;
		gpio_pins_in = 8'h00;
		lf = 8'h0B;
		ch = 8'hA5;
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		d = nx(lf);
		wr(4'h3, 8'h80);
		rd(4'h3, 8'h80);
		wr(4'h0, d);
		rd(4'h0, d);
		wr(4'h1, ~d);
		rd(4'h1, ~d);
		chk(divh, ~d);
		wr(4'h2, d);
		rd(4'h2, 8'h00);
		wr(4'h3, 8'hBF);
		wr(4'h2, 8'h10);
		rd(4'h2, 8'h10);
		for (i = 4; i < 8; i = i + 1) begin
			lf = nx(lf);
			wr(i[3:0], lf);
			rd(i[3:0], lf);
		end
		wr(4'h3, 8'h80);
		wr(4'h2, d);
		rd(4'h2, d);
		$display("test divisor and enhanced banks done");
		wr(4'h3, 8'h00);
		wr(4'h1, 8'hFF);
		rd(4'h1, 8'hFF);
		wr(4'h4, 8'hE4);
		wr(4'h6, d);
		rd(4'h6, d);
		wr(4'h7, ~d);
		rd(4'h7, ~d);
		wr(4'h4, 8'h00);
		wr(4'h2, 8'hF1);
		rd(4'h6, stat(ch));
		wr(4'h7, 8'h3C);
		wr(4'h5, 8'h00);
		rd(4'h7, 8'h3C);
		rd(4'h5, stat(ch));
		rd(4'h2, stat(ch));
		rd(4'h0, ch);
		ch = ch + 8'h35;
		wr(4'h0, d);
		wr(4'h3, 8'hBF);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		rd(4'h1, 8'h0F);
		rd(4'h2, stat(ch) & 8'hCF);
		rd(4'h8, ch & 8'h7F);
		rd(4'h9, ch & 8'h7F);
		$display("test normal bank done");
		for (i = 0; i < 12; i = i + 1) begin
			lf = nx(lf);
			wr(4'hA, lf);
			rd(4'hA, lf);
			wr(4'hC, ~lf);
			rd(4'hC, ~lf);
			wr(4'hE, lf);
			rd(4'hE, lf & 8'h0B);
			wr(4'hF, ~lf);
			rd(4'hF, ~lf & 8'hB7);
			wr(4'hD, lf);
			rd(4'hD, 8'h00);
			wr(4'hB, lf);
			gpio_pins_in <= lf ^ 8'h96;
			rd(4'hB, lf ^ 8'h96);
			chk(gout, lf);
		end
		$display("test fixed addresses done");
		complete_run;
	end
endmodule
